//--- test/relay_load.sv
// Purpose: relay coil feeding the run input of a second drive
// Assumes: coil driven by a registered terminal on the same clock
// Notes: contact follows the coil PICKUP cycles late
`timescale 1ns/10ps
module relay_load #(
  parameter int PICKUP = 2
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_reset, // synchronous reset, high
  input wire logic i_coil, // terminal driving the coil
  output logic o_forward_run_command // run input of the second drive
);
  logic [PICKUP-1:0] contact_ff;
  logic [PICKUP-1:0] nxt_contact;
  always_comb begin
    nxt_contact = i_reset ? '0 : {contact_ff[PICKUP-2:0], i_coil};
  end
  always_ff @(posedge i_clk_sys) begin
    contact_ff <= nxt_contact;
  end
  assign o_forward_run_command = contact_ff[PICKUP-1];
endmodule : relay_load

//--- test/tb.sv
// Purpose: self-checking bench of the drive status output block
// Assumes: tick shortened to 4 cycles per ms
// Notes: random stimulus from a fixed seed
`timescale 1ns/10ps
`include "drive_status_regs.svh"
module tb;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, i_run_mode = 1'b0, i_rx_strobe = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd, r;
  logic [15:0] i_pv = 16'h0000, pvv;
  logic [1:0] i_analog_loss = 2'h0;
  logic [63:0] i_status_opts = 64'h0;
  logic o_pready, o_pslverr, o_term_11, o_term_12, o_term_relay, o_irq, run_fwd, er, st, a, b, rn;
  logic [16:0] hs [8] = '{17'h00032, 17'h10032, 17'h10096, 17'h100FA, 17'h10096, 17'h10063, 17'h100C8, 17'h00096};
  logic [7:0] c;
  int err_count = 0, checked = 0, seed = 32'hcaa5;

  always #20 i_clk_sys = ~i_clk_sys;

  drive_status_output_logic #(.TICK_CYCLES(4)) drive_status_output_logic_inst (.i_clk_sys(i_clk_sys),
    .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_run_mode(i_run_mode), .i_pv(i_pv), .i_analog_loss(i_analog_loss), .i_rx_strobe(i_rx_strobe),
    .i_status_opts(i_status_opts), .o_term_11(o_term_11), .o_term_12(o_term_12),
    .o_term_relay(o_term_relay), .o_irq(o_irq));
  relay_load relay_load_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_coil(o_term_11),
    .o_forward_run_command(run_fwd));

  task end_of_test;
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc

  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 50) begin
      chk(1'b0, 1'b1, "apb no ready");
      end_of_test();
    end
  endtask : apb

  task wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, r, er);
    chk(er, 1'b0, "write error");
  endtask : wr

  task rx_pulse;
    @(posedge i_clk_sys);
    i_rx_strobe <= 1'b1;
    @(posedge i_clk_sys);
    i_rx_strobe <= 1'b0;
    #1;
  endtask : rx_pulse

  function automatic logic stage_next(logic cur, logic run, logic [15:0] pv);
    if (!run || pv > 16'h00C8) return 1'b0;
    if (pv < 16'h0064) return 1'b1;
    return cur;
  endfunction : stage_next

  function automatic logic comb_f(logic [1:0] op, logic x, logic y);
    case (op)
      drive_status_pkg::OPER_AND: return x & y;
      drive_status_pkg::OPER_OR: return x | y;
      drive_status_pkg::OPER_XOR: return x ^ y;
      default: return 1'b0;
    endcase
  endfunction : comb_f

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_count++;
    end_of_test();
  end

  initial begin
    st = 1'b0;
    repeat (16) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    cyc(2);
    chk({o_term_11, o_term_12, o_term_relay, o_irq, run_fwd}, 5'h00, "outputs after reset");
    apb(1'b0, `DS_STATUS_OFF, 32'h0, rd, er);
    chk(rd, 32'h0, "status after reset");
    apb(1'b0, `DS_PV_HIGH_OFF, 32'h0, rd, er);
    chk(rd, 32'h0000FFFF, "pv high reset");
    apb(1'b0, 8'h30, 32'h0, rd, er);
    chk(er, 1'b1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    wr(`DS_PV_LOW_OFF, 32'h00000064);
    wr(`DS_PV_HIGH_OFF, 32'h000000C8);
    wr(`DS_TSEL_OFF, 32'h00201B1F);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      rn = (i < 8) ? hs[i][16] : (r[20] | r[21]);
      pvv = (i < 8) ? hs[i][15:0] : 16'(r[15:0] % 16'h012C);
      @(posedge i_clk_sys);
      i_run_mode <= rn;
      i_pv <= pvv;
      st = stage_next(st, rn, pvv);
      cyc(5);
      chk(o_term_11, st, "second stage");
      chk(run_fwd, st, "second drive run");
    end
    apb(1'b0, `DS_IRQ_STAT_OFF, 32'h0, rd, er);
    chk(rd, 32'h0, "limits raise no event");
    @(posedge i_clk_sys);
    i_run_mode <= 1'b0;
    i_analog_loss <= 2'b01;
    cyc(3);
    chk(o_term_12, 1'b1, "analog loss in stop");
    @(posedge i_clk_sys);
    i_analog_loss <= 2'b00;
    cyc(3);
    chk(o_term_12, 1'b0, "analog loss self clear");
    wr(`DS_TRIP_OFF, 32'h00000002);
    cyc(20);
    chk(o_term_relay, 1'b0, "link loss without rtu");
    wr(`DS_CTRL_OFF, 32'h00000002);
    for (int t = 2; t < 6; t += 3) begin
      wr(`DS_TRIP_OFF, 32'(t));
      rx_pulse();
      cyc(t * 4);
      chk(o_term_relay, 1'b0, "link loss too early");
      cyc(2);
      chk(o_term_relay, 1'b1, "link loss after timeout");
      rx_pulse();
      cyc(2);
      chk(o_term_relay, 1'b0, "link loss cleared by rx");
    end
    wr(`DS_CTRL_OFF, 32'h0);
    cyc(2);
    chk(o_term_relay, 1'b0, "link loss off with rtu off");
    chk(o_irq, 1'b0, "irq masked");
    apb(1'b0, `DS_IRQ_STAT_OFF, 32'h0, rd, er);
    chk(rd, 32'h3, "event status");
    wr(`DS_IRQ_MASK_OFF, 32'h1);
    cyc(2);
    chk(o_irq, 1'b1, "irq raised");
    wr(`DS_IRQ_STAT_OFF, 32'h1);
    cyc(2);
    chk(o_irq, 1'b0, "irq cleared");
    for (int k = 0; k < 3; k++) begin
      c = 8'h21 + 8'(k);
      wr(`DS_TSEL_OFF, {8'h00, c, c, c});
      for (int op = 0; op < 4; op++) begin
        repeat (3) begin
          r = $random(seed);
          a = r[3];
          b = r[7];
          @(posedge i_clk_sys);
          i_status_opts[5] <= a;
          i_status_opts[6] <= b;
          wr(`DS_COMB0_OFF + 8'(4 * k), 32'h00000605 | (32'(op) << 16));
          cyc(4);
          chk({o_term_11, o_term_12, o_term_relay}, {3{comb_f(2'(op), a, b)}}, "combiner");
        end
      end
    end
    @(posedge i_clk_sys);
    i_status_opts <= 64'h0000000200000060;
    wr(`DS_COMB0_OFF, 32'h00010605);
    wr(8'h18, 32'h00010721);
    wr(`DS_TSEL_OFF, 32'h00000022);
    cyc(4);
    chk(o_term_11, 1'b0, "combiner result as operand");
    end_of_test();
  end
endmodule : tb

//--- verilog/drive_status_output_logic.sv
// Purpose: second stage request, link and analog loss flags, combiners, terminal routing
// Assumes: run state, pv, loss inputs and rx strobe come from logic on i_clk_sys
// Notes: apb slave answers in the second access cycle
`timescale 1ns/10ps
`include "drive_status_regs.svh"
module drive_status_output_logic #(
  parameter int TICK_CYCLES = `DS_TICK_NS / `DS_CLK_NS
) (
  input wire logic i_clk_sys, // 25 MHz clock
  input wire logic i_reset, // synchronous reset, high
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb write
  input wire logic [7:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic o_pready, // apb ready
  output logic [31:0] o_prdata, // apb read data
  output logic o_pslverr, // apb error on unmapped address
  input wire logic i_run_mode, // drive in run mode
  input wire logic [15:0] i_pv, // process variable
  input wire logic [1:0] i_analog_loss, // loss on voltage, current input
  input wire logic i_rx_strobe, // frame received pulse
  input wire logic [63:0] i_status_opts, // other status options by code
  output logic o_term_11, // transistor output 11
  output logic o_term_12, // transistor output 12
  output logic o_term_relay, // relay output
  output logic o_irq // interrupt, high
);

  // register group
  logic [1:0] ctrl_ff;
  logic [1:0] nxt_ctrl;
  logic [15:0] pv_low_ff;
  logic [15:0] nxt_pv_low;
  logic [15:0] pv_high_ff;
  logic [15:0] nxt_pv_high;
  logic [15:0] trip_ff;
  logic [15:0] nxt_trip;
  logic [2:0][5:0] tsel_ff;
  logic [2:0][5:0] nxt_tsel;
  logic [2:0][5:0] opa_ff;
  logic [2:0][5:0] nxt_opa;
  logic [2:0][5:0] opb_ff;
  logic [2:0][5:0] nxt_opb;
  logic [2:0][1:0] oper_ff;
  logic [2:0][1:0] nxt_oper;
  logic [1:0] mask_ff;
  logic [1:0] nxt_mask;
  logic pready_ff;
  logic nxt_pready;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic wr_en;
  logic [31:0] rd_data;
  logic rd_err;

  // status group
  logic stage_ff;
  logic nxt_stage;
  logic [1:0] analog_ff;
  logic link_flag;
  logic [2:0] comb_ff;
  logic [2:0] nxt_comb;
  logic [2:0] term_ff;
  logic [2:0] nxt_term;
  logic [63:0] opt_vec;
  logic [63:0] opnd_vec;

  // interrupt group
  logic [1:0] irq_stat_ff;
  logic [1:0] nxt_irq_stat;
  logic link_q_ff;
  logic ana_q_ff;
  logic irq_ff;
  logic nxt_irq;
  logic [1:0] ev;
  logic [1:0] clr;

  assign wr_en = i_psel & i_penable & pready_ff & i_pwrite;

  always_comb begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    case (i_paddr)
      `DS_CTRL_OFF: rd_data[1:0] = ctrl_ff;
      `DS_PV_LOW_OFF: rd_data[15:0] = pv_low_ff;
      `DS_PV_HIGH_OFF: rd_data[15:0] = pv_high_ff;
      `DS_TRIP_OFF: rd_data[15:0] = trip_ff;
      `DS_TSEL_OFF: rd_data = {10'h000, tsel_ff[2], 2'h0, tsel_ff[1], 2'h0, tsel_ff[0]};
      `DS_COMB0_OFF, `DS_COMB0_OFF + 8'h04, `DS_COMB0_OFF + 8'h08: begin
        rd_data = {14'h0000, oper_ff[i_paddr[3:2] - 2'h1], 2'h0,
                   opb_ff[i_paddr[3:2] - 2'h1], 2'h0, opa_ff[i_paddr[3:2] - 2'h1]};
      end
      `DS_STATUS_OFF: begin
        rd_data[`DS_ST_STAGE_BIT] = stage_ff;
        rd_data[`DS_ST_LINK_BIT] = link_flag;
        rd_data[`DS_ST_ANA_LSB +: 2] = analog_ff;
        rd_data[`DS_ST_COMB_LSB +: 3] = comb_ff;
        rd_data[`DS_ST_TERM_LSB +: 3] = term_ff;
      end
      `DS_IRQ_STAT_OFF: rd_data[1:0] = irq_stat_ff;
      `DS_IRQ_MASK_OFF: rd_data[1:0] = mask_ff;
      default: rd_err = 1'b1;
    endcase
  end

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_pv_low = pv_low_ff;
    nxt_pv_high = pv_high_ff;
    nxt_trip = trip_ff;
    nxt_tsel = tsel_ff;
    nxt_opa = opa_ff;
    nxt_opb = opb_ff;
    nxt_oper = oper_ff;
    nxt_mask = mask_ff;
    nxt_pready = i_psel & i_penable & ~pready_ff;
    nxt_prdata = nxt_pready ? rd_data : 32'h00000000;
    nxt_pslverr = nxt_pready & rd_err;
    if (wr_en) begin
      case (i_paddr)
        `DS_CTRL_OFF: nxt_ctrl = i_pwdata[1:0];
        `DS_PV_LOW_OFF: nxt_pv_low = i_pwdata[15:0];
        `DS_PV_HIGH_OFF: nxt_pv_high = i_pwdata[15:0];
        `DS_TRIP_OFF: nxt_trip = i_pwdata[15:0];
        `DS_TSEL_OFF: begin
          nxt_tsel[0] = i_pwdata[5:0];
          nxt_tsel[1] = i_pwdata[13:8];
          nxt_tsel[2] = i_pwdata[21:16];
        end
        `DS_COMB0_OFF, `DS_COMB0_OFF + 8'h04, `DS_COMB0_OFF + 8'h08: begin
          nxt_opa[i_paddr[3:2] - 2'h1] = i_pwdata[5:0];
          nxt_opb[i_paddr[3:2] - 2'h1] = i_pwdata[`DS_CFG_OPB_LSB +: 6];
          nxt_oper[i_paddr[3:2] - 2'h1] = i_pwdata[`DS_CFG_OPER_LSB +: 2];
        end
        `DS_IRQ_MASK_OFF: nxt_mask = i_pwdata[1:0];
        default: nxt_mask = mask_ff;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ctrl_ff <= `DS_CTRL_RST;
      pv_low_ff <= `DS_PV_LOW_RST;
      pv_high_ff <= `DS_PV_HIGH_RST;
      trip_ff <= `DS_TRIP_RST;
      tsel_ff <= {3{`DS_TSEL_RST}};
      opa_ff <= {3{`DS_OPND_RST}};
      opb_ff <= {3{`DS_OPND_RST}};
      oper_ff <= {3{drive_status_pkg::OPER_AND}};
      mask_ff <= `DS_MASK_RST;
      pready_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      pv_low_ff <= nxt_pv_low;
      pv_high_ff <= nxt_pv_high;
      trip_ff <= nxt_trip;
      tsel_ff <= nxt_tsel;
      opa_ff <= nxt_opa;
      opb_ff <= nxt_opb;
      oper_ff <= nxt_oper;
      mask_ff <= nxt_mask;
      pready_ff <= nxt_pready;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  link_loss_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_link_loss (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_enable(ctrl_ff[`DS_CTRL_RTU_BIT]),
    .i_rx_strobe(i_rx_strobe),
    .i_trip_ms(trip_ff),
    .o_flag(link_flag)
  );

  // request off wins when the limits overlap
  always_comb begin
    nxt_stage = stage_ff;
    if (!i_run_mode) begin
      nxt_stage = 1'b0;
    end else if (i_pv > pv_high_ff) begin
      nxt_stage = 1'b0;
    end else if (i_pv < pv_low_ff) begin
      nxt_stage = 1'b1;
    end
  end

  always_comb begin
    opt_vec = i_status_opts;
    opt_vec[`DS_OPT_STAGE] = stage_ff;
    opt_vec[`DS_OPT_ANA_O] = analog_ff[0];
    opt_vec[`DS_OPT_ANA_OI] = analog_ff[1];
    opt_vec[`DS_OPT_LINK] = link_flag;
    opt_vec[`DS_OPT_COMB0 +: 3] = comb_ff;
    opnd_vec = opt_vec;
    opnd_vec[`DS_OPT_COMB0 +: 3] = 3'h0;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_chan
      always_comb begin
        case (drive_status_pkg::oper_e'(oper_ff[g]))
          drive_status_pkg::OPER_AND: nxt_comb[g] = opnd_vec[opa_ff[g]] & opnd_vec[opb_ff[g]];
          drive_status_pkg::OPER_OR: nxt_comb[g] = opnd_vec[opa_ff[g]] | opnd_vec[opb_ff[g]];
          drive_status_pkg::OPER_XOR: nxt_comb[g] = opnd_vec[opa_ff[g]] ^ opnd_vec[opb_ff[g]];
          default: nxt_comb[g] = 1'b0;
        endcase
        nxt_term[g] = opt_vec[tsel_ff[g]];
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      stage_ff <= 1'b0;
      analog_ff <= 2'h0;
      comb_ff <= 3'h0;
      term_ff <= 3'h0;
    end else begin
      stage_ff <= nxt_stage;
      analog_ff <= i_analog_loss;
      comb_ff <= nxt_comb;
      term_ff <= nxt_term;
    end
  end

  // the limits feed no event here, only loss flags interrupt
  always_comb begin
    ev = 2'h0;
    ev[`DS_IRQ_LINK_BIT] = link_flag & ~link_q_ff;
    ev[`DS_IRQ_ANA_BIT] = (|analog_ff) & ~ana_q_ff;
    clr = (wr_en && i_paddr == `DS_IRQ_STAT_OFF) ? i_pwdata[1:0] : 2'h0;
    nxt_irq_stat = (irq_stat_ff & ~clr) | ev;
    nxt_irq = |(nxt_irq_stat & nxt_mask);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      irq_stat_ff <= 2'h0;
      link_q_ff <= 1'b0;
      ana_q_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      link_q_ff <= link_flag;
      ana_q_ff <= |analog_ff;
      irq_ff <= nxt_irq;
    end
  end

  assign o_pready = pready_ff;
  assign o_prdata = prdata_ff;
  assign o_pslverr = pslverr_ff;
  assign o_term_11 = term_ff[0];
  assign o_term_12 = term_ff[1];
  assign o_term_relay = term_ff[2];
  assign o_irq = irq_ff;

  sequence s_run_low;
    i_run_mode && i_pv < pv_low_ff && i_pv <= pv_high_ff;
  endsequence
  sequence s_in_band;
    i_run_mode && i_pv >= pv_low_ff && i_pv <= pv_high_ff;
  endsequence

  property p_stage_on;
    @(posedge i_clk_sys) disable iff (i_reset) s_run_low |=> stage_ff;
  endproperty
  a_stage_on: assert property (p_stage_on) else $error("request not set below low limit");

  property p_stage_off;
    @(posedge i_clk_sys) disable iff (i_reset) i_pv > pv_high_ff |=> !stage_ff;
  endproperty
  a_stage_off: assert property (p_stage_off) else $error("request not cleared above high limit");

  property p_stage_hold;
    @(posedge i_clk_sys) disable iff (i_reset) s_in_band ##1 s_in_band |=> $stable(stage_ff);
  endproperty
  a_stage_hold: assert property (p_stage_hold) else $error("request changed inside band");

  property p_stop_off;
    @(posedge i_clk_sys) disable iff (i_reset) $fell(i_run_mode) |=> !stage_ff;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("request not forced off at stop");

  property p_no_alarm;
    @(posedge i_clk_sys) disable iff (i_reset)
      $changed(stage_ff) && $stable(link_flag) && $stable(analog_ff) && !wr_en |=> $stable(irq_stat_ff);
  endproperty
  a_no_alarm: assert property (p_no_alarm) else $error("request raised an interrupt");

  property p_analog_follow;
    @(posedge i_clk_sys) disable iff (i_reset) ##1 analog_ff == $past(i_analog_loss);
  endproperty
  a_analog_follow: assert property (p_analog_follow) else $error("analog flag not following input");

  property p_link_off;
    @(posedge i_clk_sys) disable iff (i_reset) !ctrl_ff[`DS_CTRL_RTU_BIT] |=> !link_flag;
  endproperty
  a_link_off: assert property (p_link_off) else $error("link flag active without rtu");

  property p_link_hold;
    @(posedge i_clk_sys) disable iff (i_reset)
      link_flag && !i_rx_strobe && ctrl_ff[`DS_CTRL_RTU_BIT] |=> link_flag;
  endproperty
  a_link_hold: assert property (p_link_hold) else $error("link flag dropped before reception");

  property p_link_route;
    @(posedge i_clk_sys) disable iff (i_reset)
      tsel_ff[0] == `DS_OPT_LINK |=> o_term_11 == $past(link_flag);
  endproperty
  a_link_route: assert property (p_link_route) else $error("option 32 not routed to terminal");

  property p_xor;
    @(posedge i_clk_sys) disable iff (i_reset)
      oper_ff[0] == drive_status_pkg::OPER_XOR |=> comb_ff[0] == $past(opnd_vec[opa_ff[0]] ^ opnd_vec[opb_ff[0]]);
  endproperty
  a_xor: assert property (p_xor) else $error("combiner xor result wrong");

  property p_reset_off;
    @(posedge i_clk_sys) i_reset |=> !stage_ff && !link_flag && term_ff == 3'h0 && !o_irq;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("outputs not off after reset");

endmodule : drive_status_output_logic

//--- verilog/drive_status_pkg.sv
// Purpose: types shared by the drive status output block
// Assumes: constants live in drive_status_regs.svh
// Notes: none
package drive_status_pkg;

  typedef logic [5:0] opt_code_t;

  typedef enum logic [1:0] {
    OPER_AND = 2'b00,
    OPER_OR = 2'b01,
    OPER_XOR = 2'b10
  } oper_e;

endpackage : drive_status_pkg

//--- verilog/drive_status_regs.svh
// Purpose: offsets, field positions, reset values and timing of the drive status output block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: definitions only
// Contract
// - run and pv below low turns request on
// - pv above high turns request off
// - between limits the request holds its state
// - leaving run forces the request off
// - limits raise no alarm or interrupt
// - analog loss flag ignores run state
// - analog loss flag clears by itself
// - link loss works only with rtu selected
// - link loss holds until next reception
// - timeout comes from trip time register
// - option 32 selects link loss flag
// - operands exclude the three combiner results
// - operator is and, or or xor
// - options 33 to 35 select combiners
// - each terminal has its own option select
`ifndef DRIVE_STATUS_REGS_SVH
`define DRIVE_STATUS_REGS_SVH

`define DS_CTRL_OFF 8'h00
`define DS_PV_LOW_OFF 8'h04
`define DS_PV_HIGH_OFF 8'h08
`define DS_TRIP_OFF 8'h0C
`define DS_TSEL_OFF 8'h10
`define DS_COMB0_OFF 8'h14
`define DS_STATUS_OFF 8'h20
`define DS_IRQ_STAT_OFF 8'h24
`define DS_IRQ_MASK_OFF 8'h28

`define DS_CTRL_RUN_BIT 0
`define DS_CTRL_RTU_BIT 1

`define DS_CTRL_RST 2'h0
`define DS_PV_LOW_RST 16'h0000
`define DS_PV_HIGH_RST 16'hFFFF
`define DS_TRIP_RST 16'h0000
`define DS_TSEL_RST 6'h00
`define DS_OPND_RST 6'h00
`define DS_MASK_RST 2'h0

`define DS_ST_STAGE_BIT 0
`define DS_ST_LINK_BIT 1
`define DS_ST_ANA_LSB 2
`define DS_ST_COMB_LSB 4
`define DS_ST_TERM_LSB 8

`define DS_CFG_OPB_LSB 8
`define DS_CFG_OPER_LSB 16

`define DS_IRQ_LINK_BIT 0
`define DS_IRQ_ANA_BIT 1

`define DS_OPT_STAGE 6'h1F
`define DS_OPT_ANA_O 6'h1B
`define DS_OPT_ANA_OI 6'h1C
`define DS_OPT_LINK 6'h20
`define DS_OPT_COMB0 6'h21

`define DS_CLK_NS 40
`define DS_TICK_NS 1000000

`endif

//--- verilog/link_loss_timer.sv
// Purpose: reception timeout detector for the serial link
// Assumes: i_rx_strobe is a one-cycle pulse per received frame, same clock
// Notes: a trip time of zero disables detection
`timescale 1ns/10ps
`include "drive_status_regs.svh"
module link_loss_timer #(
  parameter int TICK_CYCLES = `DS_TICK_NS / `DS_CLK_NS
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_reset, // synchronous reset, high
  input wire logic i_enable, // rtu protocol selected
  input wire logic i_rx_strobe, // data received pulse
  input wire logic [15:0] i_trip_ms, // timeout in ms
  output logic o_flag // link loss flag
);

  logic [19:0] presc_ff;
  logic [19:0] nxt_presc;
  logic [15:0] ms_ff;
  logic [15:0] nxt_ms;
  logic flag_ff;
  logic nxt_flag;

  always_comb begin
    nxt_presc = presc_ff;
    nxt_ms = ms_ff;
    nxt_flag = flag_ff;
    if (!i_enable || i_rx_strobe) begin
      nxt_presc = 20'h00000;
      nxt_ms = 16'h0000;
      nxt_flag = 1'b0;
    end else if (!flag_ff && i_trip_ms != 16'h0000) begin
      if (presc_ff == 20'(TICK_CYCLES - 1)) begin
        nxt_presc = 20'h00000;
        nxt_ms = ms_ff + 16'h0001;
      end else begin
        nxt_presc = presc_ff + 20'h00001;
      end
      if (ms_ff >= i_trip_ms) begin
        nxt_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      presc_ff <= 20'h00000;
      ms_ff <= 16'h0000;
      flag_ff <= 1'b0;
    end else begin
      presc_ff <= nxt_presc;
      ms_ff <= nxt_ms;
      flag_ff <= nxt_flag;
    end
  end

  assign o_flag = flag_ff;

endmodule : link_loss_timer
